// File: logic/vsd_decoder.sv
// Address decoder and chain token logic of the bus slave.
// Contract
// - A24 base accepts sup/user single, BLT, MBLT
// - A32 base accepts sup/user single, BLT, MBLT
// - Code 0x2F selects configuration space
// - Base compares A23:16 or A31:16
// - Base select bit clear uses switches
// - Base select bit set uses registers
// - Geographical access A24, 0x2F, no buffer
// - Capture slot address at every reset when the aux connector is present
// - Match slot on A23:19, A18:16 zero
// - No aux connector: no geo, writable slot
// - Chained readout only A32 block codes
// - Multicast only A32 single access codes
// - Multicast writes all boards, write only
// - Chained readout reads output buffer only
// - Multicast byte register resets to 0xAA
// - Match A31:24 byte, A23:16 zero
// - Only token holder moves chain data
// - Decode first/last flags into chain position
// - Tag header and trailer with slot bits
`timescale 1ns/1ps
`default_nettype none
module vsd_decoder (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Bus cycle from the backplane
  input wire logic [31:0] addr_i,
  input wire logic [5:0] am_i,
  input wire logic as_n_i,
  input wire logic write_n_i,
  input wire logic ds_n_i,
  input wire logic iackin_n_i,
  // Board straps and switches
  input wire logic [15:0] rotary_sw_i,
  input wire logic [4:0] slot_id_lines_i,
  input wire logic aux_backplane_connector_i,
  // Configuration bits
  input wire logic base_sel_regs_i,
  input wire logic [7:0] base_addr_reg_upper_i,
  input wire logic [7:0] base_addr_reg_lower_i,
  input wire logic mcast_byte_we_i,
  input wire logic [7:0] mcast_byte_i,
  input wire logic slot_we_i,
  input wire logic [4:0] slot_wdata_i,
  input wire logic chain_first_i,
  input wire logic chain_last_i,
  // Decode results
  output logic select_o,
  output logic [2:0] mode_o,
  output logic [15:0] offset_o,
  output logic cfg_space_o,
  output logic outbuf_o,
  output logic bcast_write_o,
  output logic iackout_n_o,
  output logic [4:0] slot_addr_o,
  output logic [7:0] mcast_byte_o,
  output logic [1:0] chain_pos_o,
  output logic [4:0] data_tag_o,
  output logic tag_is_msb_o,
  // Chain data path
  input wire logic chain_done_i,
  input wire logic [31:0] word_i,
  output logic [31:0] tagged_word_o
);
  logic [31:0] addr_s;
  logic [5:0] am_s;
  logic [3:0] ctl_s;
  logic [4:0] slot_s;
  logic aux_s;
  logic as_n_s;
  logic write_n_s;
  logic ds_n_s;
  logic iackin_n_s;
  logic [4:0] slot_r;
  logic [1:0] slot_wait_r;
  logic [7:0] mcast_r;
  logic [1:0] chain_r;
  vsd_pkg::vsd_mode_e mode_nxt;
  vsd_pkg::vsd_mode_e mode_r;
  vsd_pkg::vsd_state_e state_r;
  logic [15:0] offset_r;
  logic write_r;
  logic token_r;
  logic [15:0] base_hi;
  logic [15:0] offset_nxt;
  logic is_a24;
  logic is_a32;
  logic is_blk32;
  logic is_sgl32;
  logic holds_token;

  // Every bus level and the slot straps pass two flops before use; the rotary switches are used directly.
  vsd_sync #(.W(32)) u_sync_addr (.mclk_i(mclk_i), .nrst_i(nrst_i), .d_i(addr_i), .q_o(addr_s));
  vsd_sync #(.W(6)) u_sync_am (.mclk_i(mclk_i), .nrst_i(nrst_i), .d_i(am_i), .q_o(am_s));
  vsd_sync #(.W(4)) u_sync_ctl (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .d_i({as_n_i, write_n_i, ds_n_i, iackin_n_i}),
    .q_o(ctl_s)
  );
  vsd_sync #(.W(6)) u_sync_slot (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .d_i({aux_backplane_connector_i, slot_id_lines_i}),
    .q_o({aux_s, slot_s})
  );
  assign as_n_s = ctl_s[3];
  assign write_n_s = ctl_s[2];
  assign ds_n_s = ctl_s[1];
  assign iackin_n_s = ctl_s[0];

  // Codes that a given addressing mode will take.
  function automatic logic am_a24_base(input logic [5:0] am);
    am_a24_base = (am == vsd_pkg::AM_A24_SUP_BLT) || (am == vsd_pkg::AM_A24_SUP_DATA) ||
      (am == vsd_pkg::AM_A24_SUP_MBLT) || (am == vsd_pkg::AM_A24_USR_BLT) ||
      (am == vsd_pkg::AM_A24_USR_DATA) || (am == vsd_pkg::AM_A24_USR_MBLT);
  endfunction : am_a24_base

  function automatic logic am_a32_base(input logic [5:0] am);
    am_a32_base = (am == vsd_pkg::AM_A32_SUP_BLT) || (am == vsd_pkg::AM_A32_SUP_DATA) ||
      (am == vsd_pkg::AM_A32_SUP_MBLT) || (am == vsd_pkg::AM_A32_USR_BLT) ||
      (am == vsd_pkg::AM_A32_USR_DATA) || (am == vsd_pkg::AM_A32_USR_MBLT);
  endfunction : am_a32_base

  assign is_a24 = am_a24_base(am_s);
  assign is_a32 = am_a32_base(am_s);
  assign is_blk32 = (am_s == vsd_pkg::AM_A32_SUP_BLT) || (am_s == vsd_pkg::AM_A32_USR_BLT);
  assign is_sgl32 = (am_s == vsd_pkg::AM_A32_SUP_DATA) || (am_s == vsd_pkg::AM_A32_USR_DATA);

  // Base from switches or from the two programmable bytes.
  assign base_hi = base_sel_regs_i ? {base_addr_reg_upper_i, base_addr_reg_lower_i} : rotary_sw_i;

  // With the aux connector present, the slot address is reloaded once the synchroniser has refilled after reset.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      slot_r <= vsd_pkg::SLOT_RST;
      slot_wait_r <= 2'h0;
    end
    else if (slot_wait_r != 2'h3)
    begin
      slot_wait_r <= 2'(slot_wait_r + 2'h1);
      if ((slot_wait_r == 2'h2) && aux_s)
      begin
        slot_r <= slot_s;
      end
    end
    else if (slot_we_i && !aux_s)
    begin
      slot_r <= slot_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mcast_r <= vsd_pkg::MCAST_BYTE_RST;
    end
    else if (mcast_byte_we_i)
    begin
      mcast_r <= mcast_byte_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      chain_r <= vsd_pkg::CHAIN_INACTIVE;
    end
    else
    begin
      chain_r <= {chain_first_i, chain_last_i};
    end
  end

  // Mode decode; anything not matched leaves the board silent.
  always_comb
  begin
    mode_nxt = vsd_pkg::VSD_NONE;
    offset_nxt = addr_s[15:0];
    if (am_s == vsd_pkg::AM_CFG_SPACE)
    begin
      if (aux_s && (addr_s[23:vsd_pkg::GEO_SLOT_LSB] == slot_r) && (addr_s[18:16] == 3'h0)
          && (addr_s[15:0] > vsd_pkg::OUTBUF_LAST))
      begin
        mode_nxt = vsd_pkg::VSD_GEO;
      end
    end
    else if ((chain_r != vsd_pkg::CHAIN_INACTIVE) && (addr_s[31:24] == mcast_r) && (addr_s[23:16] == 8'h00)
             && ((is_blk32 && write_n_s) || (is_sgl32 && !write_n_s)))
    begin
      if (is_blk32 && (addr_s[15:0] <= vsd_pkg::OUTBUF_LAST))
      begin
        mode_nxt = vsd_pkg::VSD_CHAIN;
      end
      else if (is_sgl32)
      begin
        mode_nxt = vsd_pkg::VSD_MCAST;
      end
    end
    else if (is_a24 && (addr_s[23:vsd_pkg::BASE_LSB] == base_hi[7:0]))
    begin
      mode_nxt = vsd_pkg::VSD_BASE24;
    end
    else if (is_a32 && (addr_s[31:vsd_pkg::BASE_LSB] == base_hi))
    begin
      mode_nxt = vsd_pkg::VSD_BASE32;
    end
  end

  // Cycle tracking: decode on address strobe, hold until it lifts.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= vsd_pkg::VSD_IDLE;
      mode_r <= vsd_pkg::VSD_NONE;
      offset_r <= 16'h0000;
      write_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        vsd_pkg::VSD_IDLE:
        begin
          if (!as_n_s)
          begin
            mode_r <= mode_nxt;
            offset_r <= offset_nxt;
            write_r <= !write_n_s;
            state_r <= (mode_nxt == vsd_pkg::VSD_NONE) ? vsd_pkg::VSD_WAIT_END : vsd_pkg::VSD_ACTIVE;
          end
        end
        vsd_pkg::VSD_ACTIVE:
        begin
          if (as_n_s)
          begin
            mode_r <= vsd_pkg::VSD_NONE;
            state_r <= vsd_pkg::VSD_IDLE;
          end
        end
        vsd_pkg::VSD_WAIT_END:
        begin
          if (as_n_s)
          begin
            state_r <= vsd_pkg::VSD_IDLE;
          end
        end
        default:
        begin
          state_r <= vsd_pkg::VSD_IDLE;
          mode_r <= vsd_pkg::VSD_NONE;
        end
      endcase
    end
  end

  // Token: the first board takes it once data strobe is low, others take it
  // from the incoming chain line; it moves on when this board is done.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      token_r <= 1'b0;
    end
    else if (as_n_s || (chain_r == vsd_pkg::CHAIN_INACTIVE))
    begin
      token_r <= 1'b0;
    end
    else if (!ds_n_s && !token_r && ((chain_r == vsd_pkg::CHAIN_FIRST) || !iackin_n_s))
    begin
      token_r <= 1'b1;
    end
  end

  logic passed_r;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      passed_r <= 1'b0;
    end
    else if (as_n_s || (chain_r == vsd_pkg::CHAIN_INACTIVE))
    begin
      passed_r <= 1'b0;
    end
    else if (token_r && chain_done_i)
    begin
      passed_r <= 1'b1;
    end
  end

  assign holds_token = token_r && !passed_r;
  assign iackout_n_o = !passed_r || (chain_r == vsd_pkg::CHAIN_LAST);

  // Chained readout only selects while this board holds the token; multicast selects on any write.
  always_comb
  begin
    case (mode_r)
      vsd_pkg::VSD_NONE: select_o = 1'b0;
      vsd_pkg::VSD_CHAIN: select_o = holds_token && !write_r;
      vsd_pkg::VSD_MCAST: select_o = write_r;
      default: select_o = 1'b1;
    endcase
  end

  assign mode_o = mode_r;
  assign offset_o = offset_r;
  assign cfg_space_o = (mode_r == vsd_pkg::VSD_GEO);
  assign outbuf_o = (offset_r <= vsd_pkg::OUTBUF_LAST) && (mode_r != vsd_pkg::VSD_GEO)
    && (mode_r != vsd_pkg::VSD_MCAST) && (mode_r != vsd_pkg::VSD_NONE);
  assign bcast_write_o = (mode_r == vsd_pkg::VSD_MCAST) && write_r;
  assign slot_addr_o = slot_r;
  assign mcast_byte_o = mcast_r;
  assign chain_pos_o = chain_r;
  assign data_tag_o = slot_r;
  assign tag_is_msb_o = 1'b1;

  // Header and trailer words carry the slot in the top five bits.
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tagged_word_o <= 32'h0000_0000;
    end
    else
    begin
      tagged_word_o <= {slot_r, word_i[vsd_pkg::TAG_LSB-1:0]};
    end
  end
endmodule : vsd_decoder
`default_nettype wire

// File: logic/vsd_pkg.sv
// Constants for the bus slave address decoder.
package vsd_pkg;
  // Address modifier codes.
  localparam logic [5:0] AM_A24_SUP_BLT = 6'h3F;
  localparam logic [5:0] AM_A24_SUP_DATA = 6'h3D;
  localparam logic [5:0] AM_A24_SUP_MBLT = 6'h3C;
  localparam logic [5:0] AM_A24_USR_BLT = 6'h3B;
  localparam logic [5:0] AM_A24_USR_DATA = 6'h39;
  localparam logic [5:0] AM_A24_USR_MBLT = 6'h38;
  localparam logic [5:0] AM_CFG_SPACE = 6'h2F;
  localparam logic [5:0] AM_A32_SUP_BLT = 6'h0F;
  localparam logic [5:0] AM_A32_SUP_DATA = 6'h0D;
  localparam logic [5:0] AM_A32_SUP_MBLT = 6'h0C;
  localparam logic [5:0] AM_A32_USR_BLT = 6'h0B;
  localparam logic [5:0] AM_A32_USR_DATA = 6'h09;
  localparam logic [5:0] AM_A32_USR_MBLT = 6'h08;
  // Field positions and widths.
  localparam int SLOT_W = 5;
  localparam int GEO_SLOT_LSB = 19;
  localparam int BASE_LSB = 16;
  localparam int TAG_LSB = 27;
  localparam int OFFSET_W = 16;
  // Reset values.
  localparam logic [7:0] MCAST_BYTE_RST = 8'hAA;
  localparam logic [4:0] SLOT_RST = 5'h00;
  // Offset window of the output buffer.
  localparam logic [15:0] OUTBUF_LAST = 16'h07FF;
  // Chain position encoding {first,last}.
  localparam logic [1:0] CHAIN_INACTIVE = 2'h0;
  localparam logic [1:0] CHAIN_LAST = 2'h1;
  localparam logic [1:0] CHAIN_FIRST = 2'h2;
  localparam logic [1:0] CHAIN_MIDDLE = 2'h3;
  typedef enum logic [2:0] {VSD_NONE, VSD_BASE24, VSD_BASE32, VSD_GEO, VSD_MCAST, VSD_CHAIN} vsd_mode_e;
  typedef enum {VSD_IDLE, VSD_ACTIVE, VSD_WAIT_END} vsd_state_e;
endpackage : vsd_pkg

// File: logic/vsd_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module vsd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule : vsd_sync
`default_nettype wire

// File: dv/vsd_checker.sv
// Port assertions for the slave address decoder.
`timescale 1ns/1ps
`default_nettype none
module vsd_checker (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Bus and configuration
  input wire logic [31:0] addr_i,
  input wire logic [5:0] am_i,
  input wire logic as_n_i,
  input wire logic write_n_i,
  input wire logic [15:0] rotary_sw_i,
  input wire logic base_sel_regs_i,
  input wire logic [7:0] base_addr_reg_upper_i,
  input wire logic [7:0] base_addr_reg_lower_i,
  // Decode results
  input wire logic select_o,
  input wire logic [2:0] mode_o,
  input wire logic [15:0] offset_o,
  input wire logic cfg_space_o,
  input wire logic [4:0] slot_addr_o,
  input wire logic [7:0] mcast_byte_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  property p_a24;
    !as_n_i && mode_o == 3'h1 |-> am_i inside {6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38};
  endproperty
  a_a24: assert property (p_a24) else $error("a24 code");
  property p_a32;
    !as_n_i && mode_o == 3'h2 |-> am_i inside {6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08};
  endproperty
  a_a32: assert property (p_a32) else $error("a32 code");
  property p_sw;
    !as_n_i && mode_o == 3'h2 && !base_sel_regs_i |-> addr_i[31:16] == rotary_sw_i;
  endproperty
  a_sw: assert property (p_sw) else $error("switch base");
  property p_reg;
    !as_n_i && mode_o == 3'h2 && base_sel_regs_i |-> addr_i[31:16] == {base_addr_reg_upper_i, base_addr_reg_lower_i};
  endproperty
  a_reg: assert property (p_reg) else $error("register base");
  property p_geo;
    !as_n_i && mode_o == 3'h3 |-> am_i == 6'h2F && cfg_space_o && addr_i[23:16] == {slot_addr_o, 3'h0}
      && addr_i[15:0] > 16'h07FF;
  endproperty
  a_geo: assert property (p_geo) else $error("geo decode");
  property p_mcast;
    !as_n_i && mode_o == 3'h4 |-> am_i inside {6'h0D, 6'h09} && !write_n_i && addr_i[31:16] == {mcast_byte_o, 8'h00};
  endproperty
  a_mcast: assert property (p_mcast) else $error("multicast decode");
  property p_chain;
    !as_n_i && mode_o == 3'h5 |-> am_i inside {6'h0F, 6'h0B} && write_n_i && offset_o <= 16'h07FF
      && addr_i[31:16] == {mcast_byte_o, 8'h00};
  endproperty
  a_chain: assert property (p_chain) else $error("chain decode");
  property p_off;
    $rose(mode_o != 3'h0) |-> offset_o == addr_i[15:0];
  endproperty
  a_off: assert property (p_off) else $error("offset");
  property p_sel;
    select_o |-> ##[0:1] mode_o != 3'h0;
  endproperty
  a_sel: assert property (p_sel) else $error("claim unmatched");
  c_geo: cover property (mode_o == 3'h3);
  c_mcast: cover property (mode_o == 3'h4);
  c_chain: cover property (mode_o == 3'h5);
endmodule : vsd_checker
bind vsd_decoder vsd_checker chk_i (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .am_i(am_i), .as_n_i(as_n_i), .write_n_i(write_n_i),
  .rotary_sw_i(rotary_sw_i), .base_sel_regs_i(base_sel_regs_i), .base_addr_reg_upper_i(base_addr_reg_upper_i),
  .base_addr_reg_lower_i(base_addr_reg_lower_i), .select_o(select_o), .mode_o(mode_o), .offset_o(offset_o),
  .cfg_space_o(cfg_space_o), .slot_addr_o(slot_addr_o), .mcast_byte_o(mcast_byte_o));
`default_nettype wire

// File: dv/vsd_master.sv
// Bus master model that runs one slave cycle at a time.
`timescale 1ns/1ps
`default_nettype none
module vsd_master (
  // Clock and answer
  input wire logic mclk_i,
  input wire logic [2:0] mode_i,
  // Bus
  output logic [31:0] addr_o,
  output logic [5:0] am_o,
  output logic as_n_o,
  output logic write_n_o,
  output logic ds_n_o
);
  initial
  begin
    addr_o = 32'h5A5A_5A5A;
    am_o = 6'h15;
    as_n_o = 1'b1;
    write_n_o = 1'b1;
    ds_n_o = 1'b1;
  end
  task automatic cyc(input logic [31:0] a, input logic [5:0] m, input logic wr, output logic [2:0] md);
    @(negedge mclk_i);
    addr_o = a;
    am_o = m;
    write_n_o = !wr;
    as_n_o = 1'b0;
    ds_n_o = 1'b0;
    repeat (4) @(negedge mclk_i);
    md = mode_i;
    // Released lines show the inverse so a stale value never matches.
    addr_o = ~a;
    am_o = ~m;
    write_n_o = wr;
    as_n_o = 1'b1;
    ds_n_o = 1'b1;
    repeat (4) @(negedge mclk_i);
  endtask : cyc
endmodule : vsd_master
`default_nettype wire

// File: dv/vme_slave_address_decoder_test.sv
// Self-checking bench for the slave address decoder.
`timescale 1ns/1ps
`default_nettype none
module vme_slave_address_decoder_test;
  logic mclk_i = 1'b0;
  logic nrst_i, as_n_i, write_n_i, ds_n_i, iackin_n_i, aux_backplane_connector_i, base_sel_regs_i;
  logic mcast_byte_we_i, slot_we_i, chain_first_i, chain_last_i, chain_done_i;
  logic select_o, cfg_space_o, outbuf_o, bcast_write_o, iackout_n_o, tag_is_msb_o;
  logic [31:0] addr_i, word_i, tagged_word_o;
  logic [15:0] rotary_sw_i, offset_o;
  logic [7:0] base_addr_reg_upper_i, base_addr_reg_lower_i, mcast_byte_i, mcast_byte_o;
  logic [5:0] am_i;
  logic [4:0] slot_id_lines_i, slot_wdata_i, slot_addr_o, data_tag_o;
  logic [2:0] mode_o;
  logic [1:0] chain_pos_o;
  logic [5:0] am_tab [12];
  int err_total;
  int n_tests;
  always #2.5 mclk_i = ~mclk_i;
  vsd_master mst (.mclk_i(mclk_i), .mode_i(mode_o), .addr_o(addr_i), .am_o(am_i), .as_n_o(as_n_i),
    .write_n_o(write_n_i), .ds_n_o(ds_n_i));
  vsd_decoder dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .am_i(am_i), .as_n_i(as_n_i), .write_n_i(write_n_i),
    .ds_n_i(ds_n_i), .iackin_n_i(iackin_n_i), .rotary_sw_i(rotary_sw_i), .slot_id_lines_i(slot_id_lines_i),
    .aux_backplane_connector_i(aux_backplane_connector_i), .base_sel_regs_i(base_sel_regs_i),
    .base_addr_reg_upper_i(base_addr_reg_upper_i), .base_addr_reg_lower_i(base_addr_reg_lower_i),
    .mcast_byte_we_i(mcast_byte_we_i), .mcast_byte_i(mcast_byte_i), .slot_we_i(slot_we_i),
    .slot_wdata_i(slot_wdata_i), .chain_first_i(chain_first_i), .chain_last_i(chain_last_i),
    .select_o(select_o), .mode_o(mode_o), .offset_o(offset_o), .cfg_space_o(cfg_space_o), .outbuf_o(outbuf_o),
    .bcast_write_o(bcast_write_o), .iackout_n_o(iackout_n_o), .slot_addr_o(slot_addr_o),
    .mcast_byte_o(mcast_byte_o), .chain_pos_o(chain_pos_o), .data_tag_o(data_tag_o), .tag_is_msb_o(tag_is_msb_o),
    .chain_done_i(chain_done_i), .word_i(word_i), .tagged_word_o(tagged_word_o));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic acc(input logic [31:0] a, input logic [5:0] m, input logic wr, input logic [2:0] exp);
    logic [2:0] md;
    logic [3:0] flags;
    // Flags are taken half a cycle after the decode lands, before the token can move on.
    fork
      mst.cyc(a, m, wr, md);
      begin
        repeat (4) @(negedge mclk_i);
        flags = {select_o, cfg_space_o, outbuf_o, bcast_write_o};
      end
    join
    chk("mode", 32'(exp), 32'(md));
    chk("flags", 32'({exp != 3'h0, exp == 3'h3, exp == 3'h5, exp == 3'h4}), 32'(flags));
  endtask : acc
  task automatic do_reset(input logic aux, input logic [4:0] slot);
    nrst_i = 1'b0;
    aux_backplane_connector_i = aux;
    slot_id_lines_i = slot;
    repeat (20) @(negedge mclk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk("mcast_byte", 32'hAA, 32'(mcast_byte_o));
  endtask : do_reset
  task automatic close_out;
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    close_out();
  end
  initial
  begin
    err_total = 0;
    n_tests = 0;
    nrst_i = 1'b0;
    iackin_n_i = 1'b1;
    rotary_sw_i = 16'hEE11;
    base_sel_regs_i = 1'b0;
    base_addr_reg_upper_i = 8'hCC;
    base_addr_reg_lower_i = 8'h22;
    {mcast_byte_we_i, slot_we_i, chain_first_i, chain_last_i, chain_done_i} = 5'h00;
    mcast_byte_i = 8'h5C;
    slot_wdata_i = 5'h0A;
    word_i = 32'hFFFF_FFFF;
    am_tab = '{6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38, 6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08};
    do_reset(1'b1, 5'h05);
    chk("slot", 32'h05, 32'(slot_addr_o));
    chk("data_tag", 32'h25, 32'({tag_is_msb_o, data_tag_o}));
    @(negedge mclk_i);
    chk("tag", {5'h05, 27'h7FF_FFFF}, tagged_word_o);
    for (int i = 0; i < 12; i++)
      acc(i < 6 ? 32'h0011_1006 : 32'hEE11_1006, am_tab[i], 1'b0, i < 6 ? 3'h1 : 3'h2);
    acc(32'h0012_1006, 6'h3D, 1'b0, 3'h0);
    acc(32'h0011_1006, 6'h3A, 1'b0, 3'h0);
    base_sel_regs_i = 1'b1;
    acc(32'hCC22_1006, 6'h0D, 1'b0, 3'h2);
    acc(32'hEE11_1006, 6'h0D, 1'b0, 3'h0);
    base_sel_regs_i = 1'b0;
    acc(32'h5528_1006, 6'h2F, 1'b0, 3'h3);
    acc(32'h0029_1006, 6'h2F, 1'b0, 3'h0);
    acc(32'h0030_1006, 6'h2F, 1'b0, 3'h0);
    acc(32'h0028_0000, 6'h2F, 1'b0, 3'h0);
    acc(32'hAA00_1006, 6'h0D, 1'b1, 3'h0);
    mcast_byte_we_i = 1'b1;
    @(negedge mclk_i);
    mcast_byte_we_i = 1'b0;
    chain_first_i = 1'b1;
    acc(32'h5C00_1006, 6'h0D, 1'b1, 3'h4);
    acc(32'h5C00_1006, 6'h09, 1'b1, 3'h4);
    chk("mcast_byte", 32'h5C, 32'(mcast_byte_o));
    acc(32'h5C00_1006, 6'h0D, 1'b0, 3'h0);
    acc(32'h5C01_1006, 6'h0D, 1'b1, 3'h0);
    acc(32'hAA00_1006, 6'h0D, 1'b1, 3'h0);
    fork
      acc(32'h5C00_0010, 6'h0F, 1'b0, 3'h5);
      begin
        repeat (4) @(negedge mclk_i);
        chain_done_i = 1'b1;
        @(negedge mclk_i);
        chain_done_i = 1'b0;
        chk("token", 32'h0, 32'(iackout_n_o));
      end
    join
    acc(32'h5C00_0010, 6'h0B, 1'b0, 3'h5);
    acc(32'h5C00_0010, 6'h0F, 1'b1, 3'h0);
    acc(32'h5C00_1006, 6'h0F, 1'b0, 3'h0);
    acc(32'h5C00_0010, 6'h3F, 1'b0, 3'h0);
    for (int i = 0; i < 4; i++)
    begin
      {chain_first_i, chain_last_i} = 2'(i);
      repeat (3) @(negedge mclk_i);
      chk("chain_pos", 32'(i), 32'(chain_pos_o));
    end
    iackin_n_i = 1'b0;
    acc(32'h5C00_0010, 6'h0F, 1'b0, 3'h5);
    iackin_n_i = 1'b1;
    chk("token", 32'h1, 32'(iackout_n_o));
    do_reset(1'b0, 5'h05);
    slot_we_i = 1'b1;
    @(negedge mclk_i);
    slot_we_i = 1'b0;
    @(negedge mclk_i);
    chk("slot", 32'h0A, 32'(slot_addr_o));
    acc(32'h0050_1006, 6'h2F, 1'b0, 3'h0);
    close_out();
  end
endmodule : vme_slave_address_decoder_test
`default_nettype wire
